/* File: hw/boot_loader_pkg.sv */
// constants and types for the serial boot loader sequencer
`default_nettype none
package boot_loader_pkg;
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned INIT_TIME_US    = 1000;
	localparam int unsigned INIT_CYCLES_DEF = (CLK_HZ / 1_000_000) * INIT_TIME_US;
	localparam int unsigned UART_BYTES      = 32;
	localparam int unsigned CAN_BYTES       = 128;
	localparam logic [23:0] BOOT_RAM_BASE   = 24'h00fa40;
	localparam logic [23:0] RESET_VECTOR    = 24'h000000;
	localparam logic [23:0] FLASH_AREA_LO   = 24'h000000;
	localparam logic [23:0] FLASH_AREA_HI   = 24'h08ffff;
	localparam logic [1:0]  TIMER_PRESCALE  = 2'h3;      // timer ticks every 4 clocks
	localparam logic [15:0] RELOAD_OFFSET   = 16'h0024;  // 36
	localparam logic [15:0] RELOAD_DIVISOR  = 16'h0048;  // 72
	localparam int unsigned BIT_SHIFT       = 5;         // bit time = 32 * (reload + 1)
	localparam logic [3:0]  FRAME_BITS      = 4'h9;      // start, 8 data, stop: index 0..9
	typedef enum logic [2:0] {
		S_INIT, S_WAIT_START, S_MEASURE, S_ACK, S_LOAD, S_JUMP, S_RUN, S_NORMAL
	} loader_state_e;
endpackage : boot_loader_pkg
`default_nettype wire

/* File: hw/serial_boot_loader.sv */
// serial boot loader mode sequencer: entry, baud measure, ack, code load, jump, exit
// Summary of operation
// - boot select low at hardware reset release enters loader mode, any bus mode.
// - in loader mode code fetches of flash area go to boot flash, data to user flash.
// - load exactly 32 bytes over UART or 128 bytes over CAN.
// - store bytes ascending in dual-port RAM starting at 00'FA40h.
// - after last byte branch to 00'FA40h, staying in loader mode.
// - watchdog disabled and user flash restricted while loader mode lasts.
// - leave loader mode on software reset, or hardware reset with select high.
// - after exit start at address zero, user flash or external per access pin.
// - bidirectional soft reset with external boot may become hardware reset, select re-read.
// - device watches receive line for zero byte: start, eight zeros, stop.
// - derive baud factor from zero byte length, program channel, enable transmit.
// - send one acknowledge byte at the derived baud rate.
// - 16-bit measure timer; reload equals timer minus 36, divided by 72.
`default_nettype none
module serial_boot_loader
	import boot_loader_pkg::*;
#(
	parameter int unsigned INIT_CYCLES = INIT_CYCLES_DEF,
	parameter logic [7:0]  ACK_BYTE    = 8'h5a  // arbitrary device acknowledge value
) (
	input  wire logic        sys_clk,              // cpu clock
	input  wire logic        resetn,               // hardware reset, async, low
	input  wire logic        softReset,            // software reset event pulse
	input  wire logic        softResetBidir,       // soft reset drives reset pin
	input  wire logic        bootSelectPin,        // low selects loader mode
	input  wire logic        externalAccessPin,    // low selects external memory
	input  wire logic        canBoot,              // link chosen is CAN
	input  wire logic        uart0ReceivePin,      // uart receive line
	output logic             uart0TransmitOut,     // uart transmit level
	output logic             uart0TransmitOe,      // uart transmit drive enable
	input  wire logic        canByteValid,         // decoded CAN payload byte
	input  wire logic [7:0]  canByte,              // CAN payload data
	output logic             canByteReady,         // CAN byte accepted
	output logic             ramWrValid,           // RAM write request
	input  wire logic        ramWrReady,           // RAM write taken
	output logic [23:0]      ramWrAddr,            // RAM write address
	output logic [7:0]       ramWrData,            // RAM write data
	input  wire logic [23:0] fetchAddr,            // access address
	input  wire logic        fetchIsCode,          // access is instruction fetch
	output logic             fetchFromBootFlash,   // route to boot flash
	output logic             fetchFromUserFlash,   // route to user flash
	output logic             bootMode,             // loader mode active
	output logic             watchdogDisable,      // watchdog held off
	output logic             userFlashRestricted,  // user flash access limited
	output logic             jumpReq,              // branch request pulse
	output logic [23:0]      jumpAddr,             // branch target
	output logic             startFromUserFlash,   // after exit boot from user flash
	output logic [15:0]      baudReload,           // programmed baud reload
	output logic             measureOverflow       // zero byte too long, sticky
);
	loader_state_e state_q;
	logic        sampleReset_q, bootMode_q, userStart_q, rxPrev_q, ovf_q;
	logic [1:0]  pre_q;
	logic [15:0] timer_q, reload_q;
	logic [23:0] initCnt_q;
	logic [21:0] txCnt_q, rxCnt_q;
	logic [3:0]  txBit_q, rxBit_q;
	logic [9:0]  txShift_q;
	logic        txOe_q, rxActive_q, rxFull_q;
	logic [7:0]  rxShift_q;
	logic [7:0]  pushCnt_q, popCnt_q;
	logic [31:0] buf0_q, buf1_q;
	logic [1:0]  bufCnt_q;

	// decode of the current state and pin events
	wire         inFlashArea = (fetchAddr >= FLASH_AREA_LO) && (fetchAddr <= FLASH_AREA_HI);
	wire         rxFall      = rxPrev_q && !uart0ReceivePin;
	wire         rxRise      = !rxPrev_q && uart0ReceivePin;
	wire         degenerate  = softReset && softResetBidir && !externalAccessPin;
	wire [7:0]   totalBytes  = canBoot ? 8'(CAN_BYTES) : 8'(UART_BYTES);
	wire [21:0]  bitCycles   = 22'({6'h00, reload_q} + 22'h1) << BIT_SHIFT;
	wire [15:0]  reloadCalc  = (timer_q < RELOAD_OFFSET) ? 16'h0000
	                         : (timer_q - RELOAD_OFFSET) / RELOAD_DIVISOR;
	wire         inLoad      = (state_q == S_LOAD) && (pushCnt_q < totalBytes);
	wire         bufReady    = (bufCnt_q != 2'h2);
	wire         pushValid   = inLoad && (canBoot ? canByteValid : rxFull_q);
	wire         push        = pushValid && bufReady;
	wire         pop         = ramWrValid && ramWrReady;
	wire [23:0]  pushAddr    = BOOT_RAM_BASE + {16'h0000, pushCnt_q};
	wire [7:0]   pushData    = canBoot ? canByte : rxShift_q;
	wire         rxSample    = rxActive_q && (rxCnt_q == 22'h0);

	// routing and mode outputs
	assign fetchFromBootFlash  = bootMode_q && fetchIsCode && inFlashArea;
	assign fetchFromUserFlash  = inFlashArea && !fetchFromBootFlash;
	assign bootMode            = bootMode_q;
	assign watchdogDisable     = bootMode_q;
	assign userFlashRestricted = bootMode_q;
	assign jumpReq             = (state_q == S_JUMP);
	assign jumpAddr            = (state_q == S_NORMAL) ? RESET_VECTOR : BOOT_RAM_BASE;
	assign startFromUserFlash  = userStart_q;
	assign baudReload          = reload_q;
	assign measureOverflow     = ovf_q;
	assign uart0TransmitOut    = txShift_q[0];
	assign uart0TransmitOe     = txOe_q;
	assign canByteReady        = inLoad && canBoot && bufReady;
	assign ramWrValid          = (bufCnt_q != 2'h0);
	assign ramWrAddr           = buf0_q[31:8];
	assign ramWrData           = buf0_q[7:0];

	// mode entry, exit and sequence
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sampleReset_q <= 1'b1;
			bootMode_q    <= 1'b0;
			userStart_q   <= 1'b0;
			state_q       <= S_NORMAL;
			initCnt_q     <= 24'h0;
		end else if (sampleReset_q || degenerate) begin
			sampleReset_q <= 1'b0;
			bootMode_q    <= !bootSelectPin;
			userStart_q   <= externalAccessPin;
			state_q       <= bootSelectPin ? S_NORMAL : S_INIT;
			initCnt_q     <= 24'h0;
		end else if (softReset) begin
			bootMode_q    <= 1'b0;
			userStart_q   <= externalAccessPin;
			state_q       <= S_NORMAL;
		end else begin
			unique case (state_q)
				S_INIT: begin
					initCnt_q <= initCnt_q + 24'h1;
					if (initCnt_q >= 24'(INIT_CYCLES - 1))
						state_q <= canBoot ? S_LOAD : S_WAIT_START;
				end
				S_WAIT_START: if (rxFall) state_q <= S_MEASURE;
				S_MEASURE: begin
					if (rxRise) state_q <= S_ACK;
					else if (timer_q == 16'hffff && pre_q == TIMER_PRESCALE)
						state_q <= S_WAIT_START;
				end
				S_ACK: if (txBit_q == FRAME_BITS && txCnt_q == 22'h0) state_q <= S_LOAD;
				S_LOAD: if (popCnt_q == totalBytes) state_q <= S_JUMP;
				S_JUMP: state_q <= S_RUN;
				S_RUN: state_q <= S_RUN;
				S_NORMAL: state_q <= S_NORMAL;
			endcase
		end
	end

	// zero byte measurement with prescaled 16-bit timer
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rxPrev_q <= 1'b1;
			pre_q    <= 2'h0;
			timer_q  <= 16'h0;
			reload_q <= 16'h0;
			ovf_q    <= 1'b0;
		end else begin
			rxPrev_q <= uart0ReceivePin;
			if (state_q == S_WAIT_START) begin
				pre_q   <= 2'h0;
				timer_q <= 16'h0;
			end else if (state_q == S_MEASURE) begin
				pre_q <= pre_q + 2'h1;
				if (rxRise)
					reload_q <= reloadCalc;
				else if (pre_q == TIMER_PRESCALE) begin
					timer_q <= timer_q + 16'h1;
					if (timer_q == 16'hffff) ovf_q <= 1'b1;
				end
			end
		end
	end

	// acknowledge transmitter at derived rate
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			txOe_q    <= 1'b0;
			txShift_q <= 10'h3ff;
			txCnt_q   <= 22'h0;
			txBit_q   <= 4'h0;
		end else if (state_q == S_MEASURE && rxRise) begin
			txOe_q    <= 1'b1;
			txShift_q <= {1'b1, ACK_BYTE, 1'b0};
			txCnt_q   <= 22'h0;
			txBit_q   <= 4'h0;
		end else if (state_q == S_ACK) begin
			if (txCnt_q == 22'h0)
				txCnt_q <= bitCycles - 22'h1;
			else
				txCnt_q <= txCnt_q - 22'h1;
			if (txCnt_q == 22'h1) begin
				txShift_q <= {1'b1, txShift_q[9:1]};
				txBit_q   <= txBit_q + 4'h1;
			end
		end else if (state_q == S_NORMAL) begin
			txOe_q <= 1'b0;
		end
	end

	// uart byte receiver, holds a byte until buffered
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rxActive_q <= 1'b0;
			rxFull_q   <= 1'b0;
			rxCnt_q    <= 22'h0;
			rxBit_q    <= 4'h0;
			rxShift_q  <= 8'h0;
		end else begin
			if (push && !canBoot) rxFull_q <= 1'b0;
			if (!rxActive_q && !rxFull_q && rxFall && inLoad && !canBoot) begin
				rxActive_q <= 1'b1;
				rxCnt_q    <= bitCycles >> 1;
				rxBit_q    <= 4'h0;
			end else if (rxActive_q) begin
				rxCnt_q <= (rxCnt_q == 22'h0) ? bitCycles - 22'h1 : rxCnt_q - 22'h1;
				if (rxSample) begin
					rxBit_q <= rxBit_q + 4'h1;
					if (rxBit_q != 4'h0 && rxBit_q != FRAME_BITS)
						rxShift_q <= {uart0ReceivePin, rxShift_q[7:1]};
					if (rxBit_q == FRAME_BITS) begin
						rxActive_q <= 1'b0;
						rxFull_q   <= 1'b1;
					end
				end
			end
		end
	end

	// two-entry buffer toward RAM with ascending address
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			buf0_q   <= 32'h0;
			buf1_q   <= 32'h0;
			bufCnt_q <= 2'h0;
			pushCnt_q <= 8'h0;
			popCnt_q  <= 8'h0;
		end else if (state_q == S_INIT || state_q == S_NORMAL) begin
			bufCnt_q  <= 2'h0;
			pushCnt_q <= 8'h0;
			popCnt_q  <= 8'h0;
		end else begin
			if (push) pushCnt_q <= pushCnt_q + 8'h1;
			if (pop) popCnt_q <= popCnt_q + 8'h1;
			bufCnt_q <= bufCnt_q + {1'b0, push} - {1'b0, pop};
			if (pop) buf0_q <= (bufCnt_q == 2'h2) ? buf1_q : {pushAddr, pushData};
			else if (push && bufCnt_q == 2'h0) buf0_q <= {pushAddr, pushData};
			if (push && (bufCnt_q == 2'h2 || (bufCnt_q == 2'h1 && !pop)))
				buf1_q <= {pushAddr, pushData};
		end
	end

	// checks
	a_mode_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
		sampleReset_q |=> bootMode == !$past(bootSelectPin)) else $error("entry wrong");
	a_code_redirect: assert property (@(posedge sys_clk) disable iff (!resetn)
		bootMode && fetchIsCode && fetchAddr <= FLASH_AREA_HI |-> fetchFromBootFlash
		&& !fetchFromUserFlash) else $error("code fetch not redirected");
	a_data_user: assert property (@(posedge sys_clk) disable iff (!resetn)
		!fetchIsCode && fetchAddr <= FLASH_AREA_HI |-> fetchFromUserFlash
		&& !fetchFromBootFlash) else $error("data route");
	a_byte_count: assert property (@(posedge sys_clk) disable iff (!resetn)
		jumpReq |-> popCnt_q == totalBytes) else $error("byte count");
	a_ram_range: assert property (@(posedge sys_clk) disable iff (!resetn)
		ramWrValid |-> ramWrAddr == BOOT_RAM_BASE + {16'h0000, popCnt_q}) else $error("ram addr");
	a_jump_stay: assert property (@(posedge sys_clk) disable iff (!resetn)
		jumpReq && !softReset |-> jumpAddr == BOOT_RAM_BASE ##1 bootMode && !jumpReq)
		else $error("jump");
	a_watchdog_off: assert property (@(posedge sys_clk) disable iff (!resetn)
		watchdogDisable == (state_q != S_NORMAL)
		&& userFlashRestricted == (state_q != S_NORMAL)) else $error("wdt");
	a_soft_exit: assert property (@(posedge sys_clk) disable iff (!resetn)
		softReset && !degenerate && !sampleReset_q |=> !bootMode && jumpAddr == RESET_VECTOR)
		else $error("soft exit");
	a_degen_reread: assert property (@(posedge sys_clk) disable iff (!resetn)
		degenerate |=> bootMode == !$past(bootSelectPin)) else $error("degenerate");
	a_reload_calc: assert property (@(posedge sys_clk) disable iff (!resetn)
		state_q == S_MEASURE && rxRise && timer_q >= 16'h0024
		|=> baudReload == ($past(timer_q) - 16'h0024) / 16'h0048) else $error("reload");
	a_tx_enable: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(uart0TransmitOe) |-> state_q == S_ACK && !uart0TransmitOut) else $error("tx en");
endmodule : serial_boot_loader
`default_nettype wire

/* File: hw/unused_placeholder_none.sv */
// intentionally empty design file
`default_nettype none
`default_nettype wire

/* File: test/uart_host_model.sv */
// host side model: sends 8N1 frames to the loader and reads its reply
`default_nettype none
module uart_host_model #(
	parameter int unsigned BIT_CYC = 64
) (
	input  wire logic sys_clk, // cpu clock
	output var logic  rxLine,  // line into the loader
	input  wire logic txOut,   // loader transmit level
	input  wire logic txOe     // loader transmit enable
);
	timeunit 1ns;
	timeprecision 1ns;
	// undriven transmit line floats high through the pull-up
	wire logic txWire = txOe ? txOut : 1'b1;
	initial rxLine = 1'b1;
	// one frame, start bit, data lsb first, stop bit
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxLine = frame[i];
			repeat (BIT_CYC) @(posedge sys_clk);
			#1;
		end
		// line rests at the stop level, so a following frame may start at once
	endtask : send_byte
	// wait a bounded time for a start bit, then sample mid-bit
	task automatic get_byte(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		while (txWire !== 1'b0 && n < 4000) begin
			@(posedge sys_clk);
			n++;
		end
		ok = (n < 4000);
		repeat (BIT_CYC / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge sys_clk);
			b[i] = txWire;
		end
		repeat (BIT_CYC) @(posedge sys_clk);
	endtask : get_byte
endmodule : uart_host_model
`default_nettype wire

/* File: test/tb_top.sv */
// bench for the boot loader sequencer: entry, uart and can loads, routing, exit
`default_nettype none
module tb_top import boot_loader_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned INIT = 20;
	localparam logic [7:0]  ACK  = 8'h5a; // arbitrary acknowledge value
	logic sys_clk = 1'b0, resetn = 1'b0, softReset = 1'b0, softResetBidir = 1'b0;
	logic bootSelectPin = 1'b0, externalAccessPin = 1'b1, canBoot = 1'b0;
	logic canByteValid = 1'b0, ramWrReady = 1'b1, fetchIsCode = 1'b0, stall = 1'b0;
	logic [7:0]  canByte = 8'h00;
	logic [23:0] fetchAddr = 24'h000000;
	logic [7:0]  expData [128];
	int          nFail = 0, testsRun = 0, ramCount = 0, jumpCount = 0, cyc = 0;
	wire logic        rxLine, txOut, txOe, canByteReady, ramWrValid, bootFl, userFl;
	wire logic        bootMode, wdDis, flRestr, jumpReq, startUser, ovf;
	wire logic [23:0] ramWrAddr, jumpAddr;
	wire logic [7:0]  ramWrData;
	wire logic [15:0] baudReload;
	serial_boot_loader #(.INIT_CYCLES(INIT), .ACK_BYTE(ACK)) serial_boot_loader_i (
		.sys_clk(sys_clk), .resetn(resetn), .softReset(softReset),
		.softResetBidir(softResetBidir), .bootSelectPin(bootSelectPin),
		.externalAccessPin(externalAccessPin), .canBoot(canBoot),
		.uart0ReceivePin(rxLine), .uart0TransmitOut(txOut), .uart0TransmitOe(txOe),
		.canByteValid(canByteValid), .canByte(canByte), .canByteReady(canByteReady),
		.ramWrValid(ramWrValid), .ramWrReady(ramWrReady), .ramWrAddr(ramWrAddr),
		.ramWrData(ramWrData), .fetchAddr(fetchAddr), .fetchIsCode(fetchIsCode),
		.fetchFromBootFlash(bootFl), .fetchFromUserFlash(userFl), .bootMode(bootMode),
		.watchdogDisable(wdDis), .userFlashRestricted(flRestr), .jumpReq(jumpReq),
		.jumpAddr(jumpAddr), .startFromUserFlash(startUser), .baudReload(baudReload),
		.measureOverflow(ovf));
	uart_host_model #(.BIT_CYC(64)) uart_host_model_i (
		.sys_clk(sys_clk), .rxLine(rxLine), .txOut(txOut), .txOe(txOe));
	always #20 sys_clk = ~sys_clk;
	task automatic finish_test();
		$display("checks run %0d, mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		testsRun++;
		if (got !== exp) begin
			nFail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	// ram sink with optional stall, jump pulse counter, run time ceiling
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (ramWrValid === 1'b1 && ramWrReady === 1'b1) begin
			check("ramWrAddr", 24'(BOOT_RAM_BASE + ramCount), ramWrAddr);
			check("ramWrData", 24'(expData[ramCount]), 24'(ramWrData));
			ramCount++;
		end
		if (jumpReq === 1'b1) jumpCount++;
		if (cyc == 60000) begin
			nFail++;
			$display("ERROR run timed out");
			finish_test();
		end
		#1 ramWrReady = stall ? (cyc[4:3] == 2'b11) : 1'b1;
	end
	task automatic hw_reset(input logic sel, input logic ea, input logic can);
		bootSelectPin = sel;
		externalAccessPin = ea;
		canBoot = can;
		resetn = 1'b0;
		step(6);
		resetn = 1'b1;
		step(2);
		ramCount = 0;
		jumpCount = 0;
		for (int i = 0; i < 128; i++) expData[i] = 8'(i * 37 + 11);
	endtask : hw_reset
	task automatic wait_jump(input int nBytes);
		for (int n = 0; n < 400 && jumpCount == 0; n++) step(1);
		step(10);
		check("jumpCount", 24'h1, 24'(jumpCount));
		check("ramCount", 24'(nBytes), 24'(ramCount));
		check("jumpAddr", BOOT_RAM_BASE, jumpAddr);
		check("bootMode", 24'h1, 24'(bootMode));
	endtask : wait_jump
	task automatic test_uart_load();
		logic [7:0] ack;
		logic ok;
		hw_reset(1'b0, 1'b1, 1'b0);
		check("bootMode", 24'h1, 24'(bootMode));
		check("wdDis", 24'h1, 24'(wdDis & flRestr));
		step(INIT + 5);
		check("txOe", 24'h0, 24'(txOe));
		fork
			uart_host_model_i.send_byte(8'h00);
			uart_host_model_i.get_byte(ack, ok);
		join
		check("ackSeen", 24'h1, 24'(ok));
		check("ack", 24'(ACK), 24'(ack));
		check("txOe", 24'h1, 24'(txOe));
		check("baudReload", 24'h1, 24'(baudReload));
		check("overflow", 24'h0, 24'(ovf));
		for (int i = 0; i < 32; i++) uart_host_model_i.send_byte(expData[i]);
		wait_jump(32);
	endtask : test_uart_load
	task automatic test_fetch(input logic inBoot);
		fetchAddr = 24'h010000;
		fetchIsCode = 1'b1;
		step(1);
		check("bootFlCode", 24'(inBoot), 24'(bootFl));
		check("userFlCode", 24'(!inBoot), 24'(userFl));
		fetchAddr = 24'h000000;
		fetchIsCode = 1'b0;
		step(1);
		check("userFlData", 24'h1, 24'({bootFl, userFl}));
	endtask : test_fetch
	task automatic soft_reset(input logic bidir);
		softReset = 1'b1;
		softResetBidir = bidir;
		step(1);
		softReset = 1'b0;
		step(3);
	endtask : soft_reset
	task automatic test_exit();
		soft_reset(1'b0);
		check("bootMode", 24'h0, 24'(bootMode));
		check("jumpAddr", RESET_VECTOR, jumpAddr);
		check("startUser", 24'h1, 24'(startUser));
		test_fetch(1'b0);
		hw_reset(1'b1, 1'b0, 1'b0);
		check("bootMode", 24'h0, 24'(bootMode));
		check("startUser", 24'h0, 24'(startUser));
		hw_reset(1'b0, 1'b0, 1'b0);
		soft_reset(1'b1);
		check("bootMode", 24'h1, 24'(bootMode));
		bootSelectPin = 1'b1;
		soft_reset(1'b1);
		check("bootMode", 24'h0, 24'(bootMode));
	endtask : test_exit
	task automatic test_can_load();
		logic refused;
		refused = 1'b0;
		hw_reset(1'b0, 1'b1, 1'b1);
		step(INIT + 5);
		stall = 1'b1;
		for (int i = 0; i < 128; i++) begin
			canByteValid = 1'b1;
			canByte = expData[i];
			for (int n = 0; n < 500 && canByteReady !== 1'b1; n++) begin
				refused = 1'b1;
				step(1);
			end
			step(1);
		end
		canByteValid = 1'b0;
		check("refused", 24'h1, 24'(refused));
		wait_jump(128);
		stall = 1'b0;
	endtask : test_can_load
	initial begin
		test_uart_load();
		test_fetch(1'b1);
		test_exit();
		test_can_load();
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
